// file: logic/pbc_defs.vh
// Purpose: Constants for the power button control block
// Assumes: 20 MHz system clock
// Notes:   Times in ms, cycle counts derived from the clock rate
`ifndef PBC_DEFS_VH
`define PBC_DEFS_VH
`define PBC_CLK_HZ         20000000
`define PBC_CYC_PER_MS     (`PBC_CLK_HZ / 1000)
`define PBC_DEBOUNCE_MS    20
`define PBC_DEBOUNCE_CYC   (`PBC_DEBOUNCE_MS * `PBC_CYC_PER_MS)
`define PBC_OVERRIDE_MS    4000
`define PBC_OVERRIDE_CYC   (`PBC_OVERRIDE_MS * `PBC_CYC_PER_MS)
`define PBC_GREEN_HALF_MS  1000
`define PBC_GREEN_HALF_CYC (`PBC_GREEN_HALF_MS * `PBC_CYC_PER_MS)
`define PBC_RED_HALF_MS    500
`define PBC_RED_HALF_CYC   (`PBC_RED_HALF_MS * `PBC_CYC_PER_MS)
`define PBC_GAP_MS         2000
`define PBC_GAP_CYC        (`PBC_GAP_MS * `PBC_CYC_PER_MS)
`define PBC_BEEP_CYCLES    5
`define PBC_CODE_MIN       2
`define PBC_CODE_MAX       10
`define PBC_CNT_W          32
`endif

// file: logic/pbc_interval.v
// Purpose: Free-running interval timer giving a one-cycle tick
// Assumes: Synchronous active-high reset
// Notes:   Restart reloads the count; tick when the interval elapses
`timescale 1ns/1ps
module pbc_interval #(
  parameter [31:0] INTERVAL = 32'h0000_0010
) (
  input  wire clk_sys,
  input  wire reset,
  input  wire restart,
  output reg  tick_ff
);
  reg [31:0] count_ff;
  always @(posedge clk_sys) begin
    if (reset || restart) begin
      count_ff <= 32'h0000_0000;
      tick_ff  <= 1'b0;
    end else if (count_ff >= INTERVAL - 32'h0000_0001) begin
      count_ff <= 32'h0000_0000;
      tick_ff  <= 1'b1;
    end else begin
      count_ff <= count_ff + 32'h0000_0001;
      tick_ff  <= 1'b0;
    end
  end
endmodule

// file: logic/pbc_power_button_control.v
// Purpose: Power button control: supply-on request, management
//          interrupt, button status, four-second override, power LED
// Assumes: All inputs synchronous to clk_sys except the raw button
// Notes:   Raw button is synchronised and debounced here
// Contract
// - Off: button press turns supply on
// - On, ACPI off: press turns supply off
// - On, ACPI on: interrupt, source, status, timer
// - Status still set at timeout: power off
// - Held four seconds then released: power off
// - LED steady green on, blink 0.5 Hz suspended
// - Fault blinks red at 1 Hz, counted
// - Same beeps, two-second gap, five cycles
// - Enabled ring wakes the system
// - Enabled power event wakes the system
`timescale 1ns/1ps
`include "pbc_defs.vh"
module pbc_power_button_control #(
  parameter [31:0] DEBOUNCE_CYC   = `PBC_DEBOUNCE_CYC,
  parameter [31:0] OVERRIDE_CYC   = `PBC_OVERRIDE_CYC,
  parameter [31:0] GREEN_HALF_CYC = `PBC_GREEN_HALF_CYC,
  parameter [31:0] RED_HALF_CYC   = `PBC_RED_HALF_CYC,
  parameter [31:0] GAP_CYC        = `PBC_GAP_CYC
) (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire       button_n,
  input  wire       acpi_enable,
  input  wire       suspend_state,
  input  wire       status_clear,
  input  wire       ring_detect,
  input  wire       ring_wake_enable,
  input  wire       pme_n,
  input  wire       pme_wake_enable,
  input  wire [3:0] fault_code,
  output reg        supply_on_request,
  output reg        mgmt_interrupt_n,
  output reg        smi_source_button,
  output reg        button_status,
  output reg        led_green,
  output reg        led_red,
  output reg        beep
);
  // Button synchroniser and debounce
  reg        btn_meta_ff;
  reg        btn_sync_ff;
  reg        btn_stable_ff;
  reg [31:0] deb_cnt_ff;
  reg        btn_prev_ff;
  wire       press;
  wire       release_ev;

  always @(posedge clk_sys) begin
    if (reset) begin
      btn_meta_ff   <= 1'b1;
      btn_sync_ff   <= 1'b1;
      btn_stable_ff <= 1'b1;
      btn_prev_ff   <= 1'b1;
      deb_cnt_ff    <= 32'h0000_0000;
    end else begin
      btn_meta_ff <= button_n;
      btn_sync_ff <= btn_meta_ff;
      btn_prev_ff <= btn_stable_ff;
      if (btn_sync_ff == btn_stable_ff) begin
        deb_cnt_ff <= 32'h0000_0000;
      end else if (deb_cnt_ff >= DEBOUNCE_CYC - 32'h0000_0001) begin
        deb_cnt_ff    <= 32'h0000_0000;
        btn_stable_ff <= btn_sync_ff;
      end else begin
        deb_cnt_ff <= deb_cnt_ff + 32'h0000_0001;
      end
    end
  end

  assign press      = btn_prev_ff & ~btn_stable_ff;
  assign release_ev = ~btn_prev_ff & btn_stable_ff;

  // Power control: override timer counts only while the system is on, hold timer whenever the button is down
  reg [31:0] ovr_cnt_ff;
  reg        ovr_run_ff;
  reg [31:0] hold_cnt_ff;
  reg        held_long_ff;
  wire       wake;

  assign wake = (ring_wake_enable & ring_detect) | (pme_wake_enable & ~pme_n);

  always @(posedge clk_sys) begin
    if (reset) begin
      supply_on_request <= 1'b0;
      mgmt_interrupt_n  <= 1'b1;
      smi_source_button <= 1'b0;
      button_status     <= 1'b0;
      ovr_cnt_ff        <= 32'h0000_0000;
      ovr_run_ff        <= 1'b0;
      hold_cnt_ff       <= 32'h0000_0000;
      held_long_ff      <= 1'b0;
    end else begin
      mgmt_interrupt_n <= 1'b1;
      // Held-press measurement
      if (btn_stable_ff) begin
        hold_cnt_ff <= 32'h0000_0000;
      end else if (hold_cnt_ff < OVERRIDE_CYC) begin
        hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
      end
      if (press) begin
        held_long_ff <= 1'b0;
      end else if (!btn_stable_ff && hold_cnt_ff >= OVERRIDE_CYC - 32'h0000_0001) begin
        held_long_ff <= 1'b1;
      end
      if (!supply_on_request) begin
        ovr_run_ff    <= 1'b0;
        ovr_cnt_ff    <= 32'h0000_0000;
        button_status <= 1'b0;
        if (press || wake) begin
          supply_on_request <= 1'b1;
        end
      end else if (release_ev && held_long_ff && acpi_enable) begin
        supply_on_request <= 1'b0;
        ovr_run_ff        <= 1'b0;
      end else if (press && !acpi_enable) begin
        supply_on_request <= 1'b0;
      end else begin
        if (press) begin
          mgmt_interrupt_n  <= 1'b0;
          smi_source_button <= 1'b1;
          button_status     <= 1'b1;
          ovr_run_ff        <= 1'b1;
          ovr_cnt_ff        <= 32'h0000_0000;
        end else begin
          if (status_clear) begin
            button_status <= 1'b0;
            ovr_run_ff    <= 1'b0;
          end
          if (ovr_run_ff) begin
            if (ovr_cnt_ff >= OVERRIDE_CYC - 32'h0000_0001) begin
              ovr_run_ff <= 1'b0;
              if (button_status && !status_clear) begin
                supply_on_request <= 1'b0;
              end
            end else begin
              ovr_cnt_ff <= ovr_cnt_ff + 32'h0000_0001;
            end
          end
        end
        if (!acpi_enable) begin
          smi_source_button <= 1'b0;
        end else if (status_clear && !press) begin
          smi_source_button <= 1'b0;
        end
      end
    end
  end

  // LED and beeper timing
  wire green_tick;
  wire red_tick;
  wire gap_tick;
  reg  gap_restart;
  reg  red_restart;
  wire fault_valid;

  assign fault_valid = (fault_code >= 4'h2) && (fault_code <= 4'ha);

  pbc_interval #(.INTERVAL(GREEN_HALF_CYC)) u_green (
    .clk_sys (clk_sys),
    .reset   (reset),
    .restart (1'b0),
    .tick_ff (green_tick)
  );
  pbc_interval #(.INTERVAL(RED_HALF_CYC)) u_red (
    .clk_sys (clk_sys),
    .reset   (reset),
    .restart (red_restart),
    .tick_ff (red_tick)
  );
  pbc_interval #(.INTERVAL(GAP_CYC)) u_gap (
    .clk_sys (clk_sys),
    .reset   (reset),
    .restart (gap_restart),
    .tick_ff (gap_tick)
  );

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_BLINK = 2'h1;
  localparam [1:0] ST_GAP   = 2'h2;
  localparam [1:0] ST_DONE  = 2'h3;

  reg [1:0] state_ff;
  reg       phase_ff;
  reg [3:0] blink_cnt_ff;
  reg [2:0] cycle_cnt_ff;
  reg       green_phase_ff;

  always @* begin
    gap_restart = (state_ff != ST_GAP);
    // Red timer held through the gap so each group starts with a full blink
    red_restart = !fault_valid || (state_ff == ST_GAP && !gap_tick);
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      state_ff       <= ST_IDLE;
      phase_ff       <= 1'b0;
      blink_cnt_ff   <= 4'h0;
      cycle_cnt_ff   <= 3'h0;
      green_phase_ff <= 1'b0;
      led_green      <= 1'b0;
      led_red        <= 1'b0;
      beep           <= 1'b0;
    end else begin
      if (green_tick) begin
        green_phase_ff <= ~green_phase_ff;
      end
      if (!fault_valid) begin
        state_ff     <= ST_IDLE;
        phase_ff     <= 1'b0;
        blink_cnt_ff <= 4'h0;
        cycle_cnt_ff <= 3'h0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            state_ff <= ST_BLINK;
            phase_ff <= 1'b1;
          end
          ST_BLINK: begin
            if (red_tick) begin
              phase_ff <= ~phase_ff;
              if (phase_ff && blink_cnt_ff == fault_code - 4'h1) begin
                blink_cnt_ff <= 4'h0;
                phase_ff     <= 1'b0;
                state_ff     <= ST_GAP;
                // Saturate so beeping never restarts after wrap
                if (cycle_cnt_ff < 3'd`PBC_BEEP_CYCLES) begin
                  cycle_cnt_ff <= cycle_cnt_ff + 3'h1;
                end
              end else if (phase_ff) begin
                blink_cnt_ff <= blink_cnt_ff + 4'h1;
              end
            end
          end
          ST_GAP: begin
            if (gap_tick) begin
              state_ff <= ST_BLINK;
              phase_ff <= 1'b1;
            end
          end
          ST_DONE: begin
            state_ff <= ST_DONE;
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
      // Red group overrides green
      led_red   <= fault_valid && state_ff == ST_BLINK && phase_ff;
      beep      <= fault_valid && state_ff == ST_BLINK && phase_ff &&
                   cycle_cnt_ff < 3'd`PBC_BEEP_CYCLES;
      led_green <= !fault_valid && supply_on_request &&
                   (!suspend_state || green_phase_ff);
    end
  end
endmodule

// file: tb/pbc_asserts.sv
// Purpose: Port checker for the power button control block
// Assumes: Bench parameters, RED_HALF_CYC of 6
// Notes:   Bound to the top module
`timescale 1ns/1ps
module pbc_asserts (
  input wire       clk_sys,
  input wire       reset,
  input wire       button_n,
  input wire       acpi_enable,
  input wire       suspend_state,
  input wire       status_clear,
  input wire       ring_detect,
  input wire       ring_wake_enable,
  input wire       pme_n,
  input wire       pme_wake_enable,
  input wire [3:0] fault_code,
  input wire       supply_on_request,
  input wire       mgmt_interrupt_n,
  input wire       smi_source_button,
  input wire       button_status,
  input wire       led_green,
  input wire       led_red,
  input wire       beep
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  int_pulse_a: assert property (!mgmt_interrupt_n |=> mgmt_interrupt_n)
    else $error("interrupt pulse longer than one cycle");
  int_cause_a: assert property ($fell(mgmt_interrupt_n) |-> acpi_enable && supply_on_request)
    else $error("interrupt without ACPI on state");
  int_flags_a: assert property ($fell(mgmt_interrupt_n) |-> ##[0:1] (button_status && smi_source_button))
    else $error("interrupt without status and source");
  off_no_int_a: assert property (!supply_on_request && $past(!supply_on_request) |-> mgmt_interrupt_n)
    else $error("interrupt while off");
  beep_red_a: assert property (beep |-> led_red)
    else $error("beep outside red blink");
  led_excl_a: assert property (led_red && $past(led_red) |-> !led_green)
    else $error("green lit during red code");
  green_on_a: assert property (led_green |-> supply_on_request || $past(supply_on_request))
    else $error("green lit while off");
  red_len_a: assert property ($rose(led_red) |-> led_red [*6])
    else $error("red blink too short");
  c_int: cover property ($fell(mgmt_interrupt_n));
  c_beep: cover property ($rose(beep));
  c_on: cover property ($rose(supply_on_request));
endmodule
bind pbc_power_button_control pbc_asserts u_chk (
  .clk_sys           (clk_sys),
  .reset             (reset),
  .button_n          (button_n),
  .acpi_enable       (acpi_enable),
  .suspend_state     (suspend_state),
  .status_clear      (status_clear),
  .ring_detect       (ring_detect),
  .ring_wake_enable  (ring_wake_enable),
  .pme_n             (pme_n),
  .pme_wake_enable   (pme_wake_enable),
  .fault_code        (fault_code),
  .supply_on_request (supply_on_request),
  .mgmt_interrupt_n  (mgmt_interrupt_n),
  .smi_source_button (smi_source_button),
  .button_status     (button_status),
  .led_green         (led_green),
  .led_red           (led_red),
  .beep              (beep)
);

// file: tb/pbc_power_button_control_tb.sv
// Purpose: Self-checking bench for power button control
// Assumes: Shortened timing parameters
// Notes:   Inputs change at the falling edge
`timescale 1ns/1ps
module pbc_power_button_control_tb;
  reg clk_sys = 0, reset = 1, button_n = 1, acpi_enable = 0, suspend_state = 0;
  reg status_clear = 0, ring_detect = 0, ring_wake_enable = 0, pme_n = 1, pme_wake_enable = 0;
  reg [3:0] fault_code = 4'h0;
  wire supply_on_request, mgmt_interrupt_n, smi_source_button, button_status;
  wire led_green, led_red, beep, main_rails, standby_rail;
  integer num_errors = 0, cmp_count = 0, ints = 0, c, n, r, b, q, k, grp, qm;
  reg g, pr, pb;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (mgmt_interrupt_n === 1'b0) ints = ints + 1;
  pbc_power_button_control #(.DEBOUNCE_CYC(4), .OVERRIDE_CYC(50), .GREEN_HALF_CYC(8),
    .RED_HALF_CYC(6), .GAP_CYC(20)) u_dut (.clk_sys(clk_sys), .reset(reset),
    .button_n(button_n), .acpi_enable(acpi_enable), .suspend_state(suspend_state),
    .status_clear(status_clear), .ring_detect(ring_detect),
    .ring_wake_enable(ring_wake_enable), .pme_n(pme_n), .pme_wake_enable(pme_wake_enable),
    .fault_code(fault_code), .supply_on_request(supply_on_request),
    .mgmt_interrupt_n(mgmt_interrupt_n), .smi_source_button(smi_source_button),
    .button_status(button_status), .led_green(led_green), .led_red(led_red), .beep(beep));
  pbc_psu_model u_psu (.supply_on_request(supply_on_request), .main_rails(main_rails),
    .standby_rail(standby_rail));
  task cyc(input integer m); repeat (m) @(negedge clk_sys); endtask
  task chk(input string nm, input integer e, input logic [7:0] s);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s exp %0d got %0d", nm, e, s);
    end
  endtask
  task press(input integer m); button_n = 0; cyc(m); button_n = 1; cyc(12); endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_plain; // Off turns on, ACPI off turns off
    press(12); chk("supply", 1, supply_on_request);
    chk("rails", 1, main_rails);
    n = ints; press(12); chk("supply", 0, supply_on_request);
    chk("ints", n, ints);
    chk("standby", 1, standby_rail);
    $display("t_plain done");
  endtask
  task t_acpi; // Press sets flags, clear avoids timeout, none forces off
    press(12); acpi_enable = 1; n = ints; press(12);
    chk("ints", n + 1, ints);
    chk("status", 1, button_status);
    chk("source", 1, smi_source_button);
    status_clear = 1; cyc(1); status_clear = 0; cyc(60);
    chk("supply", 1, supply_on_request);
    press(12); cyc(60); chk("supply", 0, supply_on_request);
    $display("t_acpi done");
  endtask
  task t_hold; // Long hold forces off
    acpi_enable = 0; press(12); acpi_enable = 1; button_n = 0; cyc(10);
    status_clear = 1; cyc(1); status_clear = 0; cyc(55);
    chk("supply held", 1, supply_on_request);
    button_n = 1; cyc(12); chk("supply", 0, supply_on_request);
    $display("t_hold done");
  endtask
  task t_wake; // Ring and power event wake
    acpi_enable = 0; ring_wake_enable = 1; ring_detect = 1; cyc(3); ring_detect = 0;
    chk("ring wake", 1, supply_on_request);
    press(12); pme_wake_enable = 1; pme_n = 0; cyc(3); pme_n = 1;
    chk("pme wake", 1, supply_on_request);
    $display("t_wake done");
  endtask
  task t_led; // Green states, red codes with beeps
    cyc(3); chk("green", 1, led_green);
    suspend_state = 1; cyc(10); g = led_green; k = 0;
    repeat (32) begin cyc(1); k = k + (led_green !== g); g = led_green; end
    chk("green toggles", 4, k);
    suspend_state = 0;
    for (c = 2; c <= 10; c = c + 1) begin
      fault_code = 4'h0; cyc(40); fault_code = c; r = 0; b = 0; q = 0; pr = 0; pb = 0;
      for (k = 0; k < 400 && !(r > 0 && q >= 15); k = k + 1) begin
        cyc(1); r = r + (led_red && !pr); b = b + (beep && !pb);
        pr = led_red; pb = beep; q = led_red ? 0 : q + 1;
      end
      chk("red blinks", c, r);
      chk("beeps", c, b);
      chk("green in fault", 0, led_green);
    end
    $display("t_led done");
  endtask
  task t_beep_stop; // Beeps end after five groups, red goes on
    fault_code = 4'h0; cyc(40); fault_code = 4'h2;
    r = 0; b = 0; q = 0; grp = 0; qm = 0; pr = 0; pb = 0;
    for (k = 0; k < 800 && grp < 9; k = k + 1) begin
      cyc(1);
      if (led_red && !pr) begin
        if (r == 0 || q >= 15) grp = grp + 1;
        r = r + 1;
      end
      b = b + (beep && !pb);
      pr = led_red; pb = beep; q = led_red ? 0 : q + 1;
      if (r > 0 && q > qm) qm = q;
    end
    chk("red groups", 9, grp);
    chk("beeps total", 10, b);
    chk("pause", 1, qm >= 20);
    fault_code = 4'h0; cyc(40);
    $display("t_beep_stop done");
  endtask
  initial begin
    cyc(20); reset = 0;
    t_plain; t_acpi; t_hold; t_wake; t_led; t_beep_stop;
    give_verdict;
  end
  initial begin
    #1000000;
    num_errors = num_errors + 1;
    give_verdict;
  end
endmodule

// file: tb/pbc_psu_model.sv
// Purpose: Power supply unit model
// Assumes: Rails follow the request at once
// Notes:   Standby rail present while AC is live
`timescale 1ns/1ps
module pbc_psu_model (
  input  wire supply_on_request,
  output wire main_rails,
  output wire standby_rail
);
  assign main_rails   = supply_on_request;
  assign standby_rail = 1'b1;
endmodule
